// file: logic/dps_snoop.sv
// Private snoop responder and owner fill/write policy for one processor.
// Assumes both processors share clock_in and that pins are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"
module dps_snoop
  import dps_pkg::*;
#(
  parameter int SETS  = `DPS_SETS,
  parameter int SET_W = `DPS_SET_W
)
(
  // Clock and reset.
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  // Configuration and role.
  input  wire logic                   dual_mode_in,
  input  wire logic                   current_bus_owner_in,
  // System bus snoop inputs.
  input  wire logic                   address_strobe_n_in,
  input  wire logic                   external_snoop_strobe_n_in,
  input  wire logic [`DPS_ADDR_W-1:0] address_in,
  // Private snoop pins, in from the partner and out to it.
  input  wire logic                   private_hit_n_in,
  input  wire logic                   private_modified_hit_n_in,
  output logic                        private_hit_n_out,
  output logic                        private_modified_hit_n_out,
  output logic                        private_hit_oe_out,
  // System snoop result pins, from system inquires only.
  input  wire logic                   sys_inquire_hit_in,
  input  wire logic                   sys_inquire_mod_in,
  output logic                        system_snoop_hit_n_out,
  output logic                        system_snoop_modified_n_out,
  // Cache fill and write requests of this processor as owner.
  input  wire logic                   fill_in,
  input  wire logic                   writeback_select_n_in,
  input  wire logic                   write_in,
  input  wire logic                   invalidate_in,
  input  wire logic [`DPS_ADDR_W-1:0] core_addr_in,
  // Write must be posted on the bus.
  output logic                        write_to_bus_out
);
  localparam int TAG_W = `DPS_ADDR_W - `DPS_LINE_LSB - SET_W;

  // Responder state and held lookup result.
  dps_state_t state_q, state_d;
  logic       hit_q, hit_d;
  logic       mod_q, mod_d;
  logic       sys_hit_q, sys_mod_q;
  logic       wtb_q;

  // Line index and tag fields of the two address sources.
  function automatic logic [SET_W-1:0] set_of(logic [`DPS_ADDR_W-1:0] a);
    set_of = a[`DPS_LINE_LSB +: SET_W];
  endfunction
  function automatic logic [TAG_W-1:0] tag_of(logic [`DPS_ADDR_W-1:0] a);
    tag_of = a[`DPS_ADDR_W-1 -: TAG_W];
  endfunction

  // Snoop lookup port and core update port of the store.
  wire logic [SET_W-1:0] rd_set;
  wire logic [TAG_W-1:0] rd_tag;
  dps_mesi_t             rd_state;
  wire logic [SET_W-1:0] cset;
  wire logic [TAG_W-1:0] ctag;
  dps_mesi_t             c_state;
  wire logic             c_hit;
  dps_mesi_t             wr_state;
  wire logic             wr_en;
  wire logic [TAG_W-1:0] c_tag_rd;

  // Non-owner strobes start a private snoop.
  wire logic is_owner = current_bus_owner_in | ~dual_mode_in;
  wire logic snoop_start = dual_mode_in & ~is_owner & (state_q == DPS_IDLE)
                         & (~address_strobe_n_in
                            | ~external_snoop_strobe_n_in);

  // Snoop lookup uses bus address bits 31 to 5 only.
  assign rd_set = set_of(address_in);
  wire logic look_hit = (rd_state != `DPS_MESI_I)
                      & (rd_tag == tag_of(address_in));
  wire logic look_mod = look_hit & (rd_state == `DPS_MESI_M);

  // Core side address decode.
  assign cset  = set_of(core_addr_in);
  assign ctag  = tag_of(core_addr_in);
  assign c_hit = (c_state != `DPS_MESI_I) & (c_tag_rd == ctag);

  // The owner samples the partner's private hit at fill time.
  wire logic partner_hit = dual_mode_in & ~private_hit_n_in;
  wire logic partner_mod = partner_hit & ~private_modified_hit_n_in;

  // Fill state: shared on private hit, else by the write-back select.
  wire logic fill_en = is_owner & fill_in;
  dps_mesi_t fill_state;
  assign fill_state = (partner_hit | writeback_select_n_in)
                    ? `DPS_MESI_S : `DPS_MESI_E;

  // Writes to a hit line: shared goes to bus, exclusive/modified stay.
  wire logic wr_hit   = is_owner & write_in & c_hit;
  wire logic wr_shared = wr_hit & (c_state == `DPS_MESI_S);
  wire logic wr_local  = wr_hit & (c_state != `DPS_MESI_S);

  // Store update: invalidate first, then fill, then write to E or M line.
  assign wr_en = invalidate_in | fill_en | wr_local;
  assign wr_state = invalidate_in ? `DPS_MESI_I
                  : fill_en       ? fill_state
                  :                 `DPS_MESI_M;

  // Tag store instance.
  dps_tag_store #(
    .SETS  (SETS),
    .SET_W (SET_W),
    .TAG_W (TAG_W)
  ) u_store (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .wr_en_in     (wr_en),
    .wr_set_in    (cset),
    .wr_tag_in    (ctag),
    .wr_state_in  (wr_state),
    .rd_set_in    (rd_set),
    .rd_tag_out   (rd_tag),
    .rd_state_out (rd_state)
  );

  // Core side read of a duplicate store kept by the same writes.
  dps_tag_store #(
    .SETS  (SETS),
    .SET_W (SET_W),
    .TAG_W (TAG_W)
  ) u_core_copy (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .wr_en_in     (wr_en),
    .wr_set_in    (cset),
    .wr_tag_in    (ctag),
    .wr_state_in  (wr_state),
    .rd_set_in    (cset),
    .rd_tag_out   (c_tag_rd),
    .rd_state_out (c_state)
  );

  // Responder sequence: look on strobe, drive result the next clock.
  always_comb
  begin
    state_d = state_q;
    hit_d   = hit_q;
    mod_d   = mod_q;
    unique case (state_q)
      DPS_IDLE:
      begin
        // Capture the lookup on the strobe edge.
        if (snoop_start)
        begin
          hit_d   = look_hit;
          mod_d   = look_mod;
          state_d = DPS_LOOK;
        end
      end
      DPS_LOOK:
      begin
        // Result is on the pins one clock after the strobe.
        state_d = DPS_DRIVE;
      end
      DPS_DRIVE:
      begin
        // Release after the owner has had its sampling clock.
        hit_d   = 1'b0;
        mod_d   = 1'b0;
        state_d = DPS_IDLE;
      end
    endcase
  end

  // Sequence and result registers.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= DPS_IDLE;
      hit_q   <= 1'b0;
      mod_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hit_q   <= hit_d;
      mod_q   <= mod_d;
    end
  end

  // System snoop pins carry only system inquire results.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sys_hit_q <= 1'b0;
      sys_mod_q <= 1'b0;
      wtb_q     <= 1'b0;
    end
    else
    begin
      sys_hit_q <= sys_inquire_hit_in;
      sys_mod_q <= sys_inquire_hit_in & sys_inquire_mod_in;
      wtb_q     <= wr_shared | (is_owner & write_in & ~c_hit);
    end
  end

  // Private pins driven only by the non-owner in dual mode.
  assign private_hit_oe_out         = dual_mode_in & ~is_owner;
  assign private_hit_n_out          = ~hit_q;
  assign private_modified_hit_n_out = ~(hit_q & mod_q);
  assign system_snoop_hit_n_out      = ~sys_hit_q;
  assign system_snoop_modified_n_out = ~sys_mod_q;
  assign write_to_bus_out            = wtb_q;

  // Unused sampled partner modified hit kept for owner visibility.
  wire logic unused_ok = partner_mod;
endmodule
`default_nettype wire

// file: logic/dps_defs.svh
// Constants for the dual processor private snoop response block.
// Assumes it is included by bare name from files under logic/.
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
`define DPS_ADDR_W      32
`define DPS_LINE_LSB    5
`define DPS_SETS        16
`define DPS_SET_W       4
`define DPS_RESP_CLOCKS 2
`define DPS_MESI_I      2'h0
`define DPS_MESI_S      2'h1
`define DPS_MESI_E      2'h2
`define DPS_MESI_M      2'h3
`endif

// file: logic/dps_pkg.sv
// Types for the dual processor private snoop response block.
// Assumes dps_defs.svh is on the include path.
`include "dps_defs.svh"
package dps_pkg;
  // Line coherence state, coded as the header constants.
  typedef logic [1:0] dps_mesi_t;
  // Snoop responder sequence.
  typedef enum logic [1:0] {DPS_IDLE, DPS_LOOK, DPS_DRIVE} dps_state_t;
endpackage

// file: logic/dps_tag_store.sv
// Direct-mapped tag and state store for the on-chip cache model.
// Assumes one clock, asynchronous active-high reset, synchronous writes.
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"
module dps_tag_store
  import dps_pkg::*;
#(
  parameter int SETS  = `DPS_SETS,
  parameter int SET_W = `DPS_SET_W,
  parameter int TAG_W = `DPS_ADDR_W - `DPS_LINE_LSB - `DPS_SET_W
)
(
  // Clock and reset.
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // Write port.
  input  wire logic             wr_en_in,
  input  wire logic [SET_W-1:0] wr_set_in,
  input  wire logic [TAG_W-1:0] wr_tag_in,
  input  wire dps_mesi_t        wr_state_in,
  // Read port, combinational.
  input  wire logic [SET_W-1:0] rd_set_in,
  output logic      [TAG_W-1:0] rd_tag_out,
  output dps_mesi_t             rd_state_out
);
  // Tag and state arrays held in flip-flops.
  logic      [TAG_W-1:0] tag_q   [SETS];
  dps_mesi_t             state_q [SETS];

  // Lookup is a plain index into the arrays.
  assign rd_tag_out   = tag_q[rd_set_in];
  assign rd_state_out = state_q[rd_set_in];

  // All lines come out of reset invalid.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < SETS; i++)
      begin
        tag_q[i]   <= '0;
        state_q[i] <= `DPS_MESI_I;
      end
    end
    else if (wr_en_in)
    begin
      tag_q[wr_set_in]   <= wr_tag_in;
      state_q[wr_set_in] <= wr_state_in;
    end
  end
endmodule
`default_nettype wire

// file: dv/dps_snoop_chk.sv
// Checker for the private snoop responder ports.
// Assumes one clock domain and binding onto dps_snoop.
`timescale 1ns/1ps
`default_nettype none
module dps_snoop_chk (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // Inputs of the responder that are watched.
  input wire logic dual_mode_in,
  input wire logic current_bus_owner_in,
  input wire logic address_strobe_n_in,
  input wire logic external_snoop_strobe_n_in,
  input wire logic sys_inquire_hit_in,
  input wire logic sys_inquire_mod_in,
  input wire logic write_in,
  // Outputs of the responder that are watched.
  input wire logic private_hit_n_out,
  input wire logic private_modified_hit_n_out,
  input wire logic private_hit_oe_out,
  input wire logic system_snoop_hit_n_out,
  input wire logic system_snoop_modified_n_out,
  input wire logic write_to_bus_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  AST_PAIR: assert property (!private_modified_hit_n_out |->
    !private_hit_n_out) else $error("modified hit without hit");
  AST_CAUSE: assert property ($fell(private_hit_n_out) |->
    !$past(address_strobe_n_in && external_snoop_strobe_n_in))
    else $error("hit without a strobe one clock before");
  AST_HOLD: assert property ($fell(private_hit_n_out) |=>
    !private_hit_n_out ##1 private_hit_n_out)
    else $error("hit not held for two clocks");
  AST_MOD_WITH: assert property (
    $fell(private_modified_hit_n_out) |-> $fell(private_hit_n_out))
    else $error("modified hit out of step");
  AST_ROLE: assert property ($fell(private_hit_n_out) |->
    $past(dual_mode_in && !current_bus_owner_in))
    else $error("hit driven by the owner");
  AST_DRIVER: assert property (private_hit_oe_out ==
    (dual_mode_in && !current_bus_owner_in)) else $error("bad enable");
  AST_SYS_HIT: assert property (1'b1 |=> system_snoop_hit_n_out ==
    !$past(sys_inquire_hit_in)) else $error("system hit wrong");
  AST_SYS_MOD: assert property (1'b1 |=>
    system_snoop_modified_n_out ==
    !$past(sys_inquire_hit_in && sys_inquire_mod_in))
    else $error("system modified wrong");
  AST_BUS_WR: assert property (write_to_bus_out |->
    $past(write_in)) else $error("bus write without a write");
  // Main scenarios reached.
  cover property ($fell(private_hit_n_out));
  cover property ($fell(private_modified_hit_n_out));
  cover property (write_to_bus_out);
endmodule
`default_nettype wire

// file: dv/dps_partner.sv
// Model of the second processor answering as non-owner.
// Assumes the bench says whether it holds the snooped line.
`timescale 1ns/1ps
`default_nettype none
module dps_partner (
  // Clock and reset.
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Role and the owner's strobe.
  input  wire logic enable_in,
  input  wire logic address_strobe_n_in,
  input  wire logic share_in,
  // Private snoop pins towards the owner.
  output logic      private_hit_n_out,
  output logic      private_modified_hit_n_out
);
  logic [1:0] left_q;  // Clocks of answer still held.
  // Answer one clock after the strobe, hold two clocks.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      left_q <= 2'h0;
    else if (left_q != 2'h0)
      left_q <= left_q - 2'h1;
    else if (enable_in && !address_strobe_n_in)
      left_q <= 2'h2;
  end
  // Idle pins rest inactive; held lines are clean.
  assign private_hit_n_out = !(left_q != 2'h0 && share_in);
  assign private_modified_hit_n_out = 1'b1;
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench for the private snoop responder with a partner model.
// Assumes outputs settle within 1 ns of a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in, rst_in, dual, owner, ads_n, external_snoop_strobe_n_n, sh, fill, wr, inv;
  logic sys_h, sys_m, wbsel_n, p_hit_n, p_mod_n, hit_n, mod_n, s_h_n;
  logic s_m_n, wbus;
  logic [31:0] addr, caddr;
  int n_mismatch, samples_checked;
  dps_snoop dut (.clock_in(clock_in), .rst_in(rst_in),
    .dual_mode_in(dual), .current_bus_owner_in(owner),
    .address_strobe_n_in(ads_n), .external_snoop_strobe_n_in(external_snoop_strobe_n_n),
    .address_in(addr), .private_hit_n_in(p_hit_n),
    .private_modified_hit_n_in(p_mod_n), .private_hit_n_out(hit_n),
    .private_modified_hit_n_out(mod_n), .private_hit_oe_out(),
    .sys_inquire_hit_in(sys_h), .sys_inquire_mod_in(sys_m),
    .system_snoop_hit_n_out(s_h_n), .system_snoop_modified_n_out(s_m_n),
    .fill_in(fill), .writeback_select_n_in(wbsel_n), .write_in(wr),
    .invalidate_in(inv), .core_addr_in(caddr), .write_to_bus_out(wbus));
  dps_partner partner (.clock_in(clock_in), .rst_in(rst_in),
    .enable_in(owner && dual), .address_strobe_n_in(ads_n),
    .share_in(sh), .private_hit_n_out(p_hit_n),
    .private_modified_hit_n_out(p_mod_n));
  // Free-running 25 MHz clock.
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // Compares one bit and counts the result.
  task automatic check(input string what, input logic seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // Owner cycle, partner answer, then the fill.
  task automatic fill_line(input logic [31:0] a, input logic s);
    @(posedge clock_in);
    addr <= a;
    ads_n <= 1'b0;
    sh <= s;
    @(posedge clock_in);
    ads_n <= 1'b1;
    @(posedge clock_in);
    fill <= 1'b1;
    caddr <= a;
    #1 check("owner_quiet", hit_n, 1'b1);
    @(posedge clock_in);
    fill <= 1'b0;
  endtask
  // Write (k=1) or invalidate (k=2), then the bus write flag.
  task automatic pulse(input int k, input logic [31:0] a, input logic e);
    @(posedge clock_in);
    caddr <= a;
    wr <= (k == 1);
    inv <= (k == 2);
    @(posedge clock_in);
    wr <= 1'b0;
    inv <= 1'b0;
    #1 check("write_to_bus", wbus, e);
  endtask
  // Strobe as non-owner and follow the answer.
  task automatic snoop(input logic e, input logic [31:0] a, input logic h, m);
    @(posedge clock_in);
    addr <= a;
    if (e)
      external_snoop_strobe_n_n <= 1'b0;
    else
      ads_n <= 1'b0;
    @(posedge clock_in);
    ads_n <= 1'b1;
    external_snoop_strobe_n_n <= 1'b1;
    // The answer stands for the two clocks after the taking edge.
    repeat (2)
    begin
      #1 check("hit", hit_n, h);
      check("modified", mod_n, m);
      check("system_hit", s_h_n, 1'b1);
      @(posedge clock_in);
    end
    #1 check("idle", hit_n, 1'b1);
  endtask
  // Exclusive fill, silent write, then snooped as modified.
  task automatic t_exclusive;
    fill_line(32'h1234_5660, 1'b0);
    pulse(1, 32'h1234_5660, 1'b0);
    @(posedge clock_in);
    owner <= 1'b0;
    snoop(1'b0, 32'h1234_5660, 1'b0, 1'b0);
    snoop(1'b0, 32'h1234_567f, 1'b0, 1'b0);
    snoop(1'b1, 32'h9234_5660, 1'b1, 1'b1);
  endtask
  // Shared fill despite write-back select, writes go out.
  task automatic t_shared;
    @(posedge clock_in);
    owner <= 1'b1;
    fill_line(32'h0abc_de80, 1'b1);
    pulse(1, 32'h0abc_de80, 1'b1);
    pulse(1, 32'h0abc_de80, 1'b1);
    @(posedge clock_in);
    owner <= 1'b0;
    snoop(1'b1, 32'h0abc_de80, 1'b0, 1'b1);
  endtask
  // Single processor: exclusive writes stay off the bus.
  task automatic t_single;
    @(posedge clock_in);
    dual <= 1'b0;
    fill_line(32'h0000_0140, 1'b0);
    pulse(1, 32'h0000_0140, 1'b0);
    pulse(2, 32'h0000_0140, 1'b0);
    pulse(1, 32'h0000_0140, 1'b1);
    @(posedge clock_in);
    sys_h <= 1'b1;
    sys_m <= 1'b1;
    @(posedge clock_in);
    sys_h <= 1'b0;
    sys_m <= 1'b0;
    #1 check("system_hit", s_h_n, 1'b0);
    check("system_modified", s_m_n, 1'b0);
    // Write-through select alone also fills shared.
    @(posedge clock_in);
    wbsel_n <= 1'b1;
    fill_line(32'h0000_0140, 1'b0);
    pulse(1, 32'h0000_0140, 1'b1);
  endtask
  // Counts and verdict.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset, then the scenarios.
  initial
  begin
    {ads_n, external_snoop_strobe_n_n, rst_in, dual, owner} = 5'h1f;
    {sh, fill, wr, inv, sys_h, sys_m, wbsel_n} = 7'h00;
    addr = 32'h0;
    caddr = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    t_exclusive();
    t_shared();
    t_single();
    tally_and_finish();
  end
endmodule
bind dps_snoop dps_snoop_chk chk (
  .clock_in                    (clock_in),
  .rst_in                      (rst_in),
  .dual_mode_in                (dual_mode_in),
  .current_bus_owner_in        (current_bus_owner_in),
  .address_strobe_n_in         (address_strobe_n_in),
  .external_snoop_strobe_n_in  (external_snoop_strobe_n_in),
  .sys_inquire_hit_in          (sys_inquire_hit_in),
  .sys_inquire_mod_in          (sys_inquire_mod_in),
  .write_in                    (write_in),
  .private_hit_n_out           (private_hit_n_out),
  .private_modified_hit_n_out  (private_modified_hit_n_out),
  .private_hit_oe_out          (private_hit_oe_out),
  .system_snoop_hit_n_out      (system_snoop_hit_n_out),
  .system_snoop_modified_n_out (system_snoop_modified_n_out),
  .write_to_bus_out            (write_to_bus_out)
);
`default_nettype wire
